// *** sim/uamp_modem_model.sv ***
module uamp_modem_model
(
  input wire logic clk_in,
  input wire uamp_pkg::uamp_modem_s lvl_in,
  output logic cts_n_out = 1'b1,
  output logic dsr_n_out = 1'b1,
  output logic dcd_n_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  import uamp_pkg::*;
  // pins move just after the edge, never on it
  always @(posedge clk_in)
  begin
    cts_n_out <= #1 ~lvl_in.cts;
    dsr_n_out <= #1 ~lvl_in.dsr;
    dcd_n_out <= #1 ~lvl_in.dcd;
  end
endmodule

// *** sim/uamp_top_sva.sv ***
module uamp_top_sva
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [4:0] paddr_in,
  input wire logic [7:0] pwdata_in,
  input wire logic [7:0] prdata_out,
  input wire logic clear_to_send_in,
  input wire logic set_ready_in,
  input wire logic carrier_detect_in,
  input wire logic term_ready_n_out,
  input wire logic modem_irq_out,
  input wire logic baud_clock_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import uamp_pkg::*;
  // ------
  // shadow state
  // ------
  logic [7:0] scr_ff, ie_ff, ctl_ff;
  logic [15:0] div_ff;
  logic [3:0] quiet_ff;
  wire wr_acc = psel_in & penable_in & pwrite_in;
  wire rd_acc = psel_in & penable_in & ~pwrite_in;
  wire rd_set = psel_in & ~penable_in & ~pwrite_in;
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      scr_ff <= RST_BYTE;
      ie_ff <= RST_BYTE;
      ctl_ff <= RST_BYTE;
      div_ff <= RST_DIVISOR;
      quiet_ff <= 4'h0;
    end
    else
    begin
      if (wr_acc && paddr_in == ADDR_SCRATCH) scr_ff <= pwdata_in;
      if (wr_acc && paddr_in == ADDR_INT_EN) ie_ff <= pwdata_in;
      if (wr_acc && paddr_in == ADDR_MODEM_CTRL) ctl_ff <= pwdata_in;
      if (wr_acc && paddr_in == ADDR_DIV_LO) div_ff[7:0] <= pwdata_in;
      if (wr_acc && paddr_in == ADDR_DIV_HI) div_ff[15:8] <= pwdata_in;
      // pins pass a sync chain, so flags lag a change
      if ($changed({clear_to_send_in, set_ready_in, carrier_detect_in}))
        quiet_ff <= 4'h0;
      else if (quiet_ff != 4'hF)
        quiet_ff <= quiet_ff + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_reset;
    disable iff (1'b0) !reset_n_in |=> prdata_out == RST_BYTE
      && !modem_irq_out && !baud_clock_out && term_ready_n_out;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset value");
  property p_scr; rd_set && paddr_in == ADDR_SCRATCH |=> prdata_out == scr_ff;
  endproperty
  a_scr: assert property (p_scr) else $error("scratch readback");
  property p_unmap; rd_set && paddr_in[4:3] != 2'b00 |=> prdata_out == RST_BYTE;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_irq_on;
    ie_ff[INT_EN_MODEM_BIT] && !ctl_ff[CTRL_LOOP_BIT] && $changed({
      clear_to_send_in, set_ready_in, carrier_detect_in}) ##1 (!psel_in)[*7]
      |-> modem_irq_out;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("no modem irq");
  property p_irq_off; !ie_ff[INT_EN_MODEM_BIT] |=> !modem_irq_out; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq masked");
  property p_clr;
    rd_acc && paddr_in == ADDR_MODEM_STATUS && quiet_ff > 4'h6
      && !ctl_ff[CTRL_LOOP_BIT] |=> ##1 !modem_irq_out;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_outs; $stable(ctl_ff) |-> term_ready_n_out ==
    (ctl_ff[CTRL_LOOP_BIT] | !ctl_ff[CTRL_TERM_READY_BIT]); endproperty
  a_outs: assert property (p_outs) else $error("ready pin");
  property p_baud; div_ff == RST_DIVISOR && $stable(div_ff) |=> !baud_clock_out;
  endproperty
  a_baud: assert property (p_baud) else $error("baud not stopped");
endmodule

bind uamp_top uamp_top_sva chk (.*);

// *** sim/uart_apb_and_modem_input_port_bench.sv ***
module uart_apb_and_modem_input_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import uamp_pkg::*;
  localparam int BAUD_DIV = 2;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [4:0] paddr_in = 5'h00;
  logic [7:0] pwdata_in = 8'h00;
  logic [7:0] prdata_out, rd;
  logic clear_to_send_in, set_ready_in, carrier_detect_in, modem_irq_out;
  logic term_ready_n_out, req_send_n_out, out1_n_out, out2_n_out;
  logic baud_clock_out;
  wire [7:0] ctl_pins = {4'h0, out2_n_out, out1_n_out, req_send_n_out,
    term_ready_n_out};
  uamp_modem_s lvl = RST_MODEM;
  uamp_modem_s old_lvl = RST_MODEM;
  logic [31:0] seed = 32'h0000_b451;
  int error_cnt = 0;
  int tests_run = 0;
  int n, k;
  uamp_top dut (.*);
  uamp_modem_model partner (.clk_in(sys_clk_in), .lvl_in(lvl),
    .cts_n_out(clear_to_send_in), .dsr_n_out(set_ready_in),
    .dcd_n_out(carrier_detect_in));
  // ------
  // helpers
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_st(input uamp_modem_s v, c);
    return {v.dcd, 1'b0, v.dsr, v.cts, c.dcd, 1'b0, c.dsr, c.cts};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_in) #1;
    psel_in = 1'b1;
    penable_in = 1'b0;
    pwrite_in = w;
    paddr_in = a;
    pwdata_in = d;
    @(posedge sys_clk_in) #1;
    penable_in = 1'b1;
    @(posedge sys_clk_in);
    rd = prdata_out;
    #1;
    psel_in = 1'b0;
    penable_in = 1'b0;
  endtask
  task automatic to_level(input logic v);
    for (n = 0; n < 100 && baud_clock_out !== v; n++) @(posedge sys_clk_in) #1;
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial forever #4 sys_clk_in = ~sys_clk_in;
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    error_cnt++;
    finish_test;
  end
  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    #1 reset_n_in = 1'b1;
    check({7'h00, baud_clock_out}, 8'h00);
    apb(1'b0, ADDR_MODEM_STATUS, 8'h00);
    check(rd, RST_BYTE);
    apb(1'b1, ADDR_INT_EN, 8'h08);
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      apb(1'b1, ADDR_SCRATCH, seed[7:0]);
      apb(1'b0, ADDR_SCRATCH, 8'h00);
      check(rd, seed[7:0]);
      lvl = (i == 0) ? RST_PINS : uamp_modem_s'(seed[10:8]);
      repeat (10) @(posedge sys_clk_in);
      #1;
      check({7'h00, modem_irq_out}, {7'h00, lvl != old_lvl});
      apb(1'b0, ADDR_MODEM_STATUS, 8'h00);
      check(rd, exp_st(lvl, lvl ^ old_lvl));
      apb(1'b0, ADDR_MODEM_STATUS, 8'h00);
      check(rd, exp_st(lvl, RST_MODEM));
      old_lvl = lvl;
    end
    apb(1'b0, 5'h1F, 8'h00);
    check(rd, RST_BYTE);
    @(posedge sys_clk_in) #1;
    psel_in = 1'b1;
    pwrite_in = 1'b1;
    paddr_in = ADDR_SCRATCH;
    pwdata_in = ~seed[7:0];
    @(posedge sys_clk_in) #1;
    psel_in = 1'b0;
    apb(1'b0, ADDR_SCRATCH, 8'h00);
    check(rd, seed[7:0]);
    apb(1'b1, ADDR_MODEM_CTRL, 8'h11);
    repeat (8) @(posedge sys_clk_in);
    apb(1'b0, ADDR_MODEM_STATUS, 8'h00);
    apb(1'b0, ADDR_MODEM_STATUS, 8'h00);
    check(rd, 8'(1 << ST_CTS_BIT));
    check({7'h00, term_ready_n_out}, 8'h01);
    check(ctl_pins, 8'h0F);
    apb(1'b1, ADDR_MODEM_CTRL, 8'h05);
    repeat (3) @(posedge sys_clk_in) #1;
    check({7'h00, term_ready_n_out}, 8'h00);
    check(ctl_pins, 8'h0A);
    apb(1'b1, ADDR_DIV_LO, 8'(BAUD_DIV));
    apb(1'b1, ADDR_DIV_HI, 8'h00);
    to_level(1'b0);
    to_level(1'b1);
    to_level(1'b0);
    k = n;
    to_level(1'b1);
    check(8'(k + n), 8'(16 * BAUD_DIV));
    finish_test;
  end
endmodule

// *** verilog/uamp_pkg.sv ***
package uamp_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_DIV_LO = 5'h00;
  localparam logic [4:0] ADDR_DIV_HI = 5'h01;
  localparam logic [4:0] ADDR_INT_EN = 5'h02;
  localparam logic [4:0] ADDR_MODEM_CTRL = 5'h04;
  localparam logic [4:0] ADDR_MODEM_STATUS = 5'h06;
  localparam logic [4:0] ADDR_SCRATCH = 5'h07;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int INT_EN_MODEM_BIT = 3;
  localparam int CTRL_TERM_READY_BIT = 0;
  localparam int CTRL_REQ_SEND_BIT = 1;
  localparam int CTRL_OUT1_BIT = 2;
  localparam int CTRL_OUT2_BIT = 3;
  localparam int CTRL_LOOP_BIT = 4;
  localparam int ST_CTS_CHG_BIT = 0;
  localparam int ST_DSR_CHG_BIT = 1;
  localparam int ST_DCD_CHG_BIT = 3;
  localparam int ST_CTS_BIT = 4;
  localparam int ST_DSR_BIT = 5;
  localparam int ST_DCD_BIT = 7;

  // ----------------------------------------------------------------------
  // reset values and baud constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0000;
  localparam logic [15:0] DIV_ONE = 16'h0001;
  localparam logic [3:0] BAUD_OVERSAMPLE_TOP = 4'hF;
  localparam int BAUD_OUT_BIT = 3;
  localparam logic [3:0] RST_OVER_CNT = 4'h0;
  localparam logic [4:0] RST_CTRL_OUT_N = 5'h1F;

  // modem levels, active high (asserted = 1)
  typedef struct packed {
    logic dcd;
    logic dsr;
    logic cts;
  } uamp_modem_s;

  localparam uamp_modem_s RST_MODEM = 3'h0;
  localparam uamp_modem_s RST_PINS = 3'h7;

endpackage

// *** verilog/uamp_top.sv ***
module uamp_top
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [4:0] paddr_in,
  input wire logic [7:0] pwdata_in,
  output logic [7:0] prdata_out,
  input wire logic clear_to_send_in,
  input wire logic set_ready_in,
  input wire logic carrier_detect_in,
  output logic term_ready_n_out,
  output logic req_send_n_out,
  output logic out1_n_out,
  output logic out2_n_out,
  output logic modem_irq_out,
  output logic baud_clock_out
);
  import uamp_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // change flag: a fresh change wins over a clear by status read
  function automatic logic delta_next(input logic prev_lvl,
                                      input logic cur_lvl,
                                      input logic flag,
                                      input logic clr);
    delta_next = (prev_lvl != cur_lvl) | (flag & ~clr);
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] div_lo_ff;
  logic [7:0] div_hi_ff;
  logic [7:0] int_en_ff;
  logic [7:0] modem_ctrl_ff;
  logic [7:0] scratch_ff;
  logic [7:0] prdata_ff;
  uamp_modem_s pin_meta_ff;
  uamp_modem_s pin_sync_ff;
  uamp_modem_s level_prev_ff;
  uamp_modem_s level_ff;
  uamp_modem_s delta_ff;
  logic modem_irq_ff;
  logic [15:0] div_cnt_ff;
  logic [3:0] over_cnt_ff;
  logic [4:0] ctrl_out_n_ff;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire access = psel_in & penable_in;
  wire wr_access = access & pwrite_in;
  wire rd_access = access & ~pwrite_in;
  wire sel_div_lo = (paddr_in == ADDR_DIV_LO);
  wire sel_div_hi = (paddr_in == ADDR_DIV_HI);
  wire sel_int_en = (paddr_in == ADDR_INT_EN);
  wire sel_ctrl = (paddr_in == ADDR_MODEM_CTRL);
  wire sel_status = (paddr_in == ADDR_MODEM_STATUS);
  wire sel_scratch = (paddr_in == ADDR_SCRATCH);
  wire status_rd = rd_access & sel_status;

  // ----------------------------------------------------------------------
  // modem status
  // ----------------------------------------------------------------------
  wire loop_mode = modem_ctrl_ff[CTRL_LOOP_BIT];
  uamp_modem_s level_pin;
  uamp_modem_s level_loop;
  uamp_modem_s nxt_level;
  uamp_modem_s nxt_delta;
  assign level_pin = ~pin_sync_ff;
  assign level_loop.cts = modem_ctrl_ff[CTRL_TERM_READY_BIT];
  assign level_loop.dsr = modem_ctrl_ff[CTRL_REQ_SEND_BIT];
  assign level_loop.dcd = modem_ctrl_ff[CTRL_OUT2_BIT];
  assign nxt_level = loop_mode ? level_loop : level_pin;
  // only flags the cpu actually saw are cleared, so a change landing
  // between the setup and access cycles of the read is not lost
  wire clr_cts = status_rd & prdata_ff[ST_CTS_CHG_BIT];
  wire clr_dsr = status_rd & prdata_ff[ST_DSR_CHG_BIT];
  wire clr_dcd = status_rd & prdata_ff[ST_DCD_CHG_BIT];
  assign nxt_delta.cts = delta_next(level_prev_ff.cts, level_ff.cts,
                                    delta_ff.cts, clr_cts);
  assign nxt_delta.dsr = delta_next(level_prev_ff.dsr, level_ff.dsr,
                                    delta_ff.dsr, clr_dsr);
  assign nxt_delta.dcd = delta_next(level_prev_ff.dcd, level_ff.dcd,
                                    delta_ff.dcd, clr_dcd);

  logic [7:0] status_byte;
  always_comb
  begin
    status_byte = RST_BYTE;
    status_byte[ST_CTS_CHG_BIT] = delta_ff.cts;
    status_byte[ST_DSR_CHG_BIT] = delta_ff.dsr;
    status_byte[ST_DCD_CHG_BIT] = delta_ff.dcd;
    status_byte[ST_CTS_BIT] = level_ff.cts;
    status_byte[ST_DSR_BIT] = level_ff.dsr;
    status_byte[ST_DCD_BIT] = level_ff.dcd;
  end

  wire nxt_irq = int_en_ff[INT_EN_MODEM_BIT] & (|nxt_delta);

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // sampled in the setup cycle so data is steady through the access cycle
  wire [7:0] nxt_prdata =
    sel_div_lo ? div_lo_ff :
    sel_div_hi ? div_hi_ff :
    sel_int_en ? int_en_ff :
    sel_ctrl ? modem_ctrl_ff :
    sel_status ? status_byte :
    sel_scratch ? scratch_ff : RST_BYTE;

  // ----------------------------------------------------------------------
  // baud divider
  // ----------------------------------------------------------------------
  // divisor zero stops the baud clock instead of dividing by 65536
  wire [15:0] divisor = {div_hi_ff, div_lo_ff};
  wire div_run = (divisor != RST_DIVISOR);
  wire div_tick = div_run & (div_cnt_ff == (divisor - DIV_ONE));
  wire [15:0] nxt_div_cnt = (div_tick | ~div_run) ? RST_DIVISOR :
                            (div_cnt_ff + DIV_ONE);
  wire over_wrap = (over_cnt_ff == BAUD_OVERSAMPLE_TOP);
  wire [3:0] over_inc = over_wrap ? RST_OVER_CNT : (over_cnt_ff + 4'h1);
  wire [3:0] nxt_over_cnt = ~div_run ? RST_OVER_CNT :
                            div_tick ? over_inc : over_cnt_ff;

  // ----------------------------------------------------------------------
  // strobes and next values
  // ----------------------------------------------------------------------
  wire wr_div_lo = wr_access & sel_div_lo;
  wire wr_div_hi = wr_access & sel_div_hi;
  wire wr_int_en = wr_access & sel_int_en;
  wire wr_ctrl = wr_access & sel_ctrl;
  wire wr_scratch = wr_access & sel_scratch;
  wire rd_setup = psel_in & ~penable_in & ~pwrite_in;
  uamp_modem_s pin_raw;
  assign pin_raw = {carrier_detect_in, set_ready_in, clear_to_send_in};
  // loopback keeps the modem outputs idle
  wire [4:0] nxt_ctrl_out_n = loop_mode ? RST_CTRL_OUT_N :
    {1'b1, ~modem_ctrl_ff[CTRL_OUT2_BIT:CTRL_TERM_READY_BIT]};

  // ----------------------------------------------------------------------
  // bus registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      div_lo_ff <= RST_BYTE;
    else if (wr_div_lo)
      div_lo_ff <= pwdata_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      div_hi_ff <= RST_BYTE;
    else if (wr_div_hi)
      div_hi_ff <= pwdata_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      int_en_ff <= RST_BYTE;
    else if (wr_int_en)
      int_en_ff <= pwdata_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      modem_ctrl_ff <= RST_BYTE;
    else if (wr_ctrl)
      modem_ctrl_ff <= pwdata_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      scratch_ff <= RST_BYTE;
    else if (wr_scratch)
      scratch_ff <= pwdata_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      prdata_ff <= RST_BYTE;
    else if (rd_setup)
      prdata_ff <= nxt_prdata;
  end

  // ----------------------------------------------------------------------
  // modem status pipeline
  // ----------------------------------------------------------------------
  // first flop may go metastable; only pin_sync_ff reads it
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      pin_meta_ff <= RST_PINS;
    else
      pin_meta_ff <= pin_raw;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      pin_sync_ff <= RST_PINS;
    else
      pin_sync_ff <= pin_meta_ff;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      level_ff <= RST_MODEM;
    else
      level_ff <= nxt_level;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      level_prev_ff <= RST_MODEM;
    else
      level_prev_ff <= level_ff;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      delta_ff <= RST_MODEM;
    else
      delta_ff <= nxt_delta;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      modem_irq_ff <= 1'b0;
    else
      modem_irq_ff <= nxt_irq;
  end

  // ----------------------------------------------------------------------
  // baud divider
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      div_cnt_ff <= RST_DIVISOR;
    else
      div_cnt_ff <= nxt_div_cnt;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      over_cnt_ff <= RST_OVER_CNT;
    else
      over_cnt_ff <= nxt_over_cnt;
  end

  // ----------------------------------------------------------------------
  // modem control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
      ctrl_out_n_ff <= RST_CTRL_OUT_N;
    else
      ctrl_out_n_ff <= nxt_ctrl_out_n;
  end

  assign prdata_out = prdata_ff;
  assign term_ready_n_out = ctrl_out_n_ff[CTRL_TERM_READY_BIT];
  assign req_send_n_out = ctrl_out_n_ff[CTRL_REQ_SEND_BIT];
  assign out1_n_out = ctrl_out_n_ff[CTRL_OUT1_BIT];
  assign out2_n_out = ctrl_out_n_ff[CTRL_OUT2_BIT];
  assign modem_irq_out = modem_irq_ff;
  assign baud_clock_out = over_cnt_ff[BAUD_OUT_BIT];

endmodule
